// [shared/rrl_pkg.sv]
// package for the return and rotate-left execute block
package rrl_pkg;
	localparam int rrl_opcode_width = 14;
	localparam int rrl_data_width = 8;
	localparam int rrl_file_index_width = 7;
	localparam int rrl_pc_width = 13;
	// return-with-literal: 11 01xx kkkk kkkk
	localparam logic [3:0] rrl_retlit_match = 4'hd;
	localparam int rrl_retlit_match_msb = 13;
	localparam int rrl_retlit_match_lsb = 10;
	// rotate left: 00 1101 dfff ffff
	localparam logic [5:0] rrl_rotl_match = 6'h0d;
	localparam int rrl_rotl_match_msb = 13;
	localparam int rrl_rotl_match_lsb = 8;
	localparam int rrl_dest_bit = 7;
	// plain return: 00 0000 0000 1000
	localparam logic [13:0] rrl_return_code = 14'h0008;
	// instruction cycles
	localparam int rrl_return_cycles = 2;
	localparam int rrl_rotl_cycles = 1;
	localparam logic [7:0] rrl_accum_reset = 8'h00;
	localparam logic rrl_carry_reset = 1'h0;

	typedef enum logic [1:0]
	{
		rrl_state_exec = 2'b00,
		rrl_state_flush = 2'b01
	} rrl_state_type;

	// decoded instruction fields
	typedef struct packed
	{
		logic is_retlit;
		logic is_return;
		logic is_rotl;
		logic dest_file;
		logic [rrl_file_index_width-1:0] file_index;
		logic [rrl_data_width-1:0] literal;
	} rrl_decode_type;

	// register file write request
	typedef struct packed
	{
		logic write;
		logic [rrl_file_index_width-1:0] index;
		logic [rrl_data_width-1:0] data;
	} rrl_file_write_type;
endpackage : rrl_pkg

// [hw/rrl_decode.sv]
// opcode decoder for the three handled instructions
`timescale 1ns/1ps
`default_nettype none
module rrl_decode
	import rrl_pkg::*;
(
	input wire logic [rrl_opcode_width-1:0] opcode,
	output rrl_decode_type decoded
);
	// the two x bits of the literal return are never compared
	always_comb
	begin
		decoded.is_retlit = (opcode[rrl_retlit_match_msb:rrl_retlit_match_lsb] == rrl_retlit_match);
		decoded.is_return = (opcode == rrl_return_code);
		decoded.is_rotl = (opcode[rrl_rotl_match_msb:rrl_rotl_match_lsb] == rrl_rotl_match);
		decoded.dest_file = opcode[rrl_dest_bit];
		decoded.file_index = opcode[rrl_file_index_width-1:0];
		decoded.literal = opcode[rrl_data_width-1:0];
	end
endmodule : rrl_decode
`default_nettype wire

// [hw/rrl_exec.sv]
// execute stage for literal return, plain return and rotate left through carry
`timescale 1ns/1ps
`default_nettype none
module rrl_exec
	import rrl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic instr_valid,
	input wire logic [rrl_opcode_width-1:0] opcode,
	input wire logic [rrl_pc_width-1:0] stack_head,
	input wire logic [rrl_data_width-1:0] file_read_data,
	output logic [rrl_file_index_width-1:0] file_read_index,
	output logic stack_pop,
	output logic pc_load,
	output logic [rrl_pc_width-1:0] pc_load_value,
	output logic flush_prefetch,
	output logic busy,
	output rrl_file_write_type file_write,
	output logic [rrl_data_width-1:0] accumulator,
	output logic carry
);
	// decoded view of the word on the opcode port
	rrl_decode_type decoded;

	// sequencing state and its next value
	rrl_state_type state;
	rrl_state_type next_state;

	// a word is accepted this cycle
	logic take;

	// accepted word is one of the two returns
	logic take_ret;

	// accepted word is a rotate
	logic take_rotl;

	// rotated operand, formed from the live read data
	logic [rrl_data_width-1:0] rotated;

	// next values of the registered outputs
	logic next_pulse;
	logic [rrl_pc_width-1:0] next_pc_load_value;
	logic [rrl_data_width-1:0] next_accumulator;
	logic next_carry;
	rrl_file_write_type next_file_write;

	// shift one place left, old carry into bit 0
	function automatic logic [rrl_data_width-1:0] rrl_rotate_left
	(
		input logic [rrl_data_width-1:0] value,
		input logic carry_in
	);
		return {value[rrl_data_width-2:0], carry_in};
	endfunction : rrl_rotate_left

	// bit pushed out of the top becomes the new carry
	function automatic logic rrl_carry_out
	(
		input logic [rrl_data_width-1:0] value
	);
		return value[rrl_data_width-1];
	endfunction : rrl_carry_out

	// either return form needs the pop and the idle slot
	function automatic logic rrl_is_any_return
	(
		input rrl_decode_type word
	);
		return word.is_retlit || word.is_return;
	endfunction : rrl_is_any_return

	rrl_decode u_decode
	(
		.opcode(opcode),
		.decoded(decoded)
	);

	// in the idle slot the prefetched word is thrown away
	assign take = instr_valid && (state == rrl_state_exec);
	assign take_ret = take && rrl_is_any_return(decoded);
	assign take_rotl = take && decoded.is_rotl;

	// the core reads the indexed register in the same cycle
	assign file_read_index = decoded.file_index;
	assign rotated = rrl_rotate_left(file_read_data, carry);

	// busy marks the idle second cycle of a return
	assign busy = (state == rrl_state_flush);

	// returns hold the core one extra cycle
	always_comb
	begin
		next_state = rrl_state_exec;
		case (state)
			rrl_state_exec:
			begin
				if (take_ret)
					next_state = rrl_state_flush;
			end
			rrl_state_flush:
				next_state = rrl_state_exec;
			default:
				next_state = rrl_state_exec;
		endcase
	end

	// sequencing state
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			state <= rrl_state_exec;
		else
			state <= next_state;
	end

	// pop, load and flush share one pulse; head sampled while the return is accepted
	always_comb
	begin
		next_pulse = take_ret;
		next_pc_load_value = pc_load_value;
		if (take_ret)
			next_pc_load_value = stack_head;
	end

	// stack pop strobe
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			stack_pop <= 1'b0;
		else
			stack_pop <= next_pulse;
	end

	// counter load strobe
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			pc_load <= 1'b0;
		else
			pc_load <= next_pulse;
	end

	// prefetch flush strobe, so the core refetches from the new counter
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			flush_prefetch <= 1'b0;
		else
			flush_prefetch <= next_pulse;
	end

	// return address holds until the next return, so a slow core may read it late
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			pc_load_value <= '0;
		else
			pc_load_value <= next_pc_load_value;
	end

	// only literal return and rotate with clear destination write the accumulator
	always_comb
	begin
		next_accumulator = accumulator;
		if (take && decoded.is_retlit)
			next_accumulator = decoded.literal;
		else if (take_rotl && !decoded.dest_file)
			next_accumulator = rotated;
	end

	// accumulator register
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			accumulator <= rrl_accum_reset;
		else
			accumulator <= next_accumulator;
	end

	// carry is touched by the rotate only; returns leave it alone
	always_comb
	begin
		next_carry = carry;
		if (take_rotl)
			next_carry = rrl_carry_out(file_read_data);
	end

	// carry flag register
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			carry <= rrl_carry_reset;
		else
			carry <= next_carry;
	end

	// write request only for a set destination; index and data are don't-care otherwise
	always_comb
	begin
		next_file_write = '0;
		next_file_write.write = take_rotl && decoded.dest_file;
		next_file_write.index = decoded.file_index;
		next_file_write.data = rotated;
	end

	// register file write-back, one cycle after the rotate is taken
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			file_write <= '0;
		else
			file_write <= next_file_write;
	end
endmodule : rrl_exec
`default_nettype wire

// [verif/rrl_exec_sva.sv]
// assertions for the return and rotate-left execute block
`timescale 1ns/1ps
`default_nettype none
module rrl_exec_sva
	import rrl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic instr_valid,
	input wire logic [13:0] opcode,
	input wire logic [12:0] stack_head,
	input wire logic [7:0] file_read_data,
	input wire logic [6:0] file_read_index,
	input wire logic stack_pop,
	input wire logic pc_load,
	input wire logic [12:0] pc_load_value,
	input wire logic flush_prefetch,
	input wire logic busy,
	input wire rrl_file_write_type file_write,
	input wire logic [7:0] accumulator,
	input wire logic carry
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// taken words only, busy cycle drops them
	wire rl = instr_valid && !busy && opcode[13:10] == 4'hd;
	wire rt = rl || (instr_valid && !busy && opcode == 14'h0008);
	wire ro = instr_valid && !busy && opcode[13:8] == 6'h0d;
	lit_load_a: assert property (rl |=> accumulator == $past(opcode[7:0])) else $error("lit");
	ret_pop_a: assert property (rt |=> pc_load && stack_pop && flush_prefetch && pc_load_value == $past(stack_head)) else $error("pop");
	two_cycle_a: assert property (rt |=> busy ##1 !busy) else $error("len");
	ret_flag_a: assert property (rt |=> $stable(carry) && !file_write.write) else $error("flag");
	rot_carry_a: assert property (ro |=> carry == $past(file_read_data[7]) && !busy) else $error("c");
	rot_acc_a: assert property (ro && !opcode[7] |=> accumulator == {$past(file_read_data[6:0]), $past(carry)}) else $error("w");
	rot_wr_a: assert property (ro && opcode[7] |=> file_write[15] && file_write[14:8] == $past(file_read_index) && $stable(accumulator)) else $error("f");
	idle_slot_a: assert property (busy |=> !stack_pop && !pc_load && !busy && $stable(carry)) else $error("idle");
endmodule : rrl_exec_sva
bind rrl_exec rrl_exec_sva rrl_chk (.*);
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the return and rotate-left execute block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rrl_pkg::*;
	logic clk_sys = 0, reset = 1, instr_valid = 0, m_c = 0, stack_pop, pc_load, flush_prefetch, busy, carry;
	logic [13:0] opcode = 0;
	logic [12:0] stack_head = 0, pc_load_value;
	logic [7:0] file_read_data = 0, m_acc = 0, accumulator;
	logic [6:0] file_read_index;
	rrl_file_write_type file_write;
	int bad_count = 0, checked = 0, k;
	rrl_exec uut (.*);
	always #5 clk_sys = ~clk_sys;
	task chk(input logic [16:0] g, e);
		checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("CHECK FAILED %0t %h %h", $time, g, e);
		end
	endtask : chk
	task results;
		if (bad_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	// one word offered at the falling edge, model updated alongside
	task run(input logic [13:0] op, input logic v);
		logic [7:0] e;
		logic r;
		logic w;
		instr_valid = v;
		opcode = op;
		file_read_data = 8'($urandom);
		stack_head = 13'($urandom);
		e = {file_read_data[6:0], m_c};
		r = v && (op[13:10] == 4'hd || op == 14'h0008);
		w = v && op[13:8] == 6'h0d && op[7];
		@(negedge clk_sys);
		if (r)
		begin
			chk({busy, stack_pop, pc_load, flush_prefetch, pc_load_value}, {4'hf, stack_head});
			m_acc = op[13] ? op[7:0] : m_acc;
			opcode = 14'h0d85; // prefetched word, must be dropped
			@(negedge clk_sys);
			chk({busy, stack_pop, file_write.write}, 0);
		end
		else
		begin
			if (v && op[13:8] == 6'h0d)
			begin
				if (op[7])
					chk(file_write, {1'b1, op[6:0], e});
				else
					m_acc = e;
				m_c = file_read_data[7];
			end
			chk({busy, stack_pop, pc_load, flush_prefetch, file_write.write}, {4'h0, w});
		end
		chk({accumulator, carry}, {m_acc, m_c});
	endtask : run
	initial
	begin
		void'($urandom(32'h5440a258));
		repeat (5) @(negedge clk_sys);
		reset = 0;
		run(14'h37ff, 1);
		// mix of all three words, unknown words and idle cycles
		repeat (400)
		begin
			k = $urandom % 4;
			run(k == 0 ? 14'h0008 : k == 1 ? 14'h3400 | 14'($urandom % 1024) : k == 2 ? 14'h0d00 | 14'($urandom % 256)
				: 14'($urandom), $urandom % 8 != 0);
		end
		results();
	end
endmodule : tb_top
`default_nettype wire
